// *** hdl/gtu_timer_unit.v ***
// general timer unit: two modules of 16-bit up/down timers behind an apb slave
// assumes pins are asynchronous, held at least one prescaled tick, single 20 MHz clock
`timescale 1ns/1ps
`include "gtu_timer_regs.vh"

module gtu_timer_unit #(
  parameter PRE_W = 10
) (
  input  wire        core_clk_in,
  input  wire        nrst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire [4:0]  timer_input_pin_in,
  input  wire [4:0]  direction_input_pin_in,
  input  wire        capture_trigger_pin_in,
  output reg         core_one_toggle_pin_out,
  output reg         core_two_toggle_pin_out,
  output reg         capcom_clock_out
);

  // timer index: 0 aux_timer_low, 1 core_timer_one, 2 aux_timer_high,
  // 3 aux_timer_two, 4 core_timer_two

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  wire [10:0] pins_raw = {capture_trigger_pin_in, direction_input_pin_in,
                          timer_input_pin_in};
  reg  [10:0] sy1;
  reg  [10:0] sy2;
  reg  [10:0] sy3;
  wire [10:0] rise = sy2 & ~sy3;
  wire [10:0] fall = ~sy2 & sy3;
  wire [10:0] edge_any = rise | fall;

  // logic reads only sy2 and sy3; sy1 may still be settling
  // pin sampling
  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      sy1 <= 11'h000;
      sy2 <= 11'h000;
      sy3 <= 11'h000;
    end else begin
      sy1 <= pins_raw;
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and state

  reg [PRE_W-1:0] pre;
  reg [79:0]      cnt;
  reg [79:0]      ctl;
  reg [15:0]      capreg;
  reg [15:0]      capctl;
  reg             l1;
  reg             l1d;
  reg             l2;
  reg             l2d;

  // tick when the low n bits of the prescaler are all ones
  function tick_fn;
    input [PRE_W-1:0] p;
    input [3:0]       n;
    reg   [PRE_W-1:0] m;
    begin
      m = ({{(PRE_W-1){1'b0}}, 1'b1} << n) - {{(PRE_W-1){1'b0}}, 1'b1};
      tick_fn = ((p & m) == m);
    end
  endfunction

  // delayed latch copies turn each latch change into a one-cycle strobe
  wire tog1  = l1 ^ l1d;
  wire tog2  = l2 ^ l2d;
  wire lrise = l1 & ~l1d;
  wire lfall = ~l1 & l1d;

  ////////////////////////////////////////////////////////////////////////////
  // per-timer stepping

  wire [4:0] step;
  wire [4:0] up;
  wire [4:0] wrap;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : tmr
      wire [15:0] c    = ctl[g*16 +: 16];
      wire [15:0] v    = cnt[g*16 +: 16];
      wire        one  = (g < 3);
      // block two has no gated or incremental mode
      wire [1:0]  md   = one ? c[`GTU_F_MODE_LO +: 2] : {c[`GTU_F_MODE_LO+1], 1'b0};
      wire [3:0]  nb   = {1'b0, c[`GTU_F_PRE_LO +: 3]} +
                         (one ? `GTU_BASE_ONE : `GTU_BASE_TWO);
      wire        ptk  = tick_fn(pre, nb);
      wire        gpin = sy2[g];
      wire        dpin = sy2[5+g];
      // limitation: counter mode follows every synchronised rising input edge and
      // incremental mode every edge of either pin, so only pin timing keeps them to the tick base
      // quadrature decode
      wire        qstp = edge_any[g] | edge_any[5+g];
      wire        qup  = sy3[g] ^ sy2[5+g];
      reg         src;
      always @* begin
        case (md)
          `GTU_MODE_TIMER:   src = ptk;
          `GTU_MODE_GATED:   src = ptk & (gpin == c[`GTU_F_GATE_LVL]);
          `GTU_MODE_COUNTER: src = rise[g];
          default:           src = qstp;
        endcase
      end
      // latch clocks aux timer two
      // core timers never chain: their own latch is the chain source
      wire chain = (g == 0 || g == 2) ? tog1 : ((g == 3) ? tog2 : 1'b0);
      wire can_chain = (g != 1) && (g != 4);
      wire halt = (g == 0 || g == 2) && (c[`GTU_F_FUNC_LO +: 2] != 2'h0);
      assign step[g] = c[`GTU_F_RUN] & ~halt &
                       ((can_chain && c[`GTU_F_CHAIN]) ? chain : src);
      assign up[g] = (one && md == `GTU_MODE_INCR) ? qup :
                     ~(c[`GTU_F_DOWN] ^ (c[`GTU_F_EXT_DIR] & dpin));
      assign wrap[g] = step[g] & ((up[g] & (v == `GTU_MAX_CNT)) |
                                  (~up[g] & (v == `GTU_RST_WORD)));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // captures, reloads and next counts

  function rld_fn;
    input [15:0] c;
    input        pin_rise;
    input        lr;
    input        lf;
    begin
      rld_fn = (c[`GTU_F_FUNC_LO +: 2] == `GTU_FUNC_RELOAD) &
               ((lr & c[`GTU_F_TRIG_RISE]) | (lf & c[`GTU_F_TRIG_FALL]) |
                (pin_rise & c[`GTU_F_TRIG_PIN]));
    end
  endfunction

  function cap_fn;
    input [15:0] c;
    input        pr;
    input        pf;
    begin
      cap_fn = (c[`GTU_F_FUNC_LO +: 2] == `GTU_FUNC_CAPTURE) &
               ((pr & c[`GTU_F_TRIG_RISE]) | (pf & c[`GTU_F_TRIG_FALL]));
    end
  endfunction

  wire cap_ev = (capctl[`GTU_C_PIN_RISE] & rise[10]) |
                (capctl[`GTU_C_PIN_FALL] & fall[10]) |
                (capctl[`GTU_C_CORE_IN] & edge_any[1]) |
                (capctl[`GTU_C_CORE_DIR] & edge_any[6]);

  // counters, captures and reloads resolve in one process so the order of
  // the overrides below is the priority between them
  reg [79:0] next_cnt;
  integer    i;

  always @* begin
    for (i = 0; i < 5; i = i + 1) begin
      if (step[i] && up[i])
        next_cnt[i*16 +: 16] = cnt[i*16 +: 16] + 16'h0001;
      else if (step[i])
        next_cnt[i*16 +: 16] = cnt[i*16 +: 16] - 16'h0001;
      else
        next_cnt[i*16 +: 16] = cnt[i*16 +: 16];
    end
    if (cap_fn(ctl[15:0], rise[0], fall[0]))
      next_cnt[15:0] = cnt[31:16];
    if (cap_fn(ctl[47:32], rise[2], fall[2]))
      next_cnt[47:32] = cnt[31:16];
    // aux_low wins when both aux timers ask to reload in one cycle
    // reload of core timer one
    // low reload on rising, high on falling edge gives pwm
    if (rld_fn(ctl[15:0], rise[0], lrise, lfall))
      next_cnt[31:16] = cnt[15:0];
    else if (rld_fn(ctl[47:32], rise[2], lrise, lfall))
      next_cnt[31:16] = cnt[47:32];
    if (cap_ev && capctl[`GTU_C_CLEAR])
      next_cnt[63:48] = `GTU_RST_WORD;
    if (wrap[4] && capctl[`GTU_C_RELOAD])
      next_cnt[79:64] = capreg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  // zero wait states: pready follows every setup by one cycle; a write
  // answer also shows the old register value, which masters ignore
  wire       setup  = psel_in & ~penable_in;
  wire       wr_acc = psel_in & penable_in & pwrite_in & pready_out;
  wire [5:0] widx   = paddr_in[7:2];
  reg  [31:0] next_rdata;
  reg         next_err;

  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (paddr_in[1:0] != 2'h0)
      next_err = 1'b1;
    else if (paddr_in < (`GTU_CTL_BASE + 8'h14))
      next_rdata = {16'h0000, ctl[(widx - `GTU_CTL_BASE/4)*16 +: 16]};
    else if (paddr_in >= `GTU_CNT_BASE && paddr_in < `GTU_CAPTURE_RELOAD_REG)
      next_rdata = {16'h0000, cnt[(widx - `GTU_CNT_BASE/4)*16 +: 16]};
    else if (paddr_in == `GTU_CAPTURE_RELOAD_REG)
      next_rdata = {16'h0000, capreg};
    else if (paddr_in == `GTU_CAPCTL)
      next_rdata = {16'h0000, capctl};
    else if (paddr_in == `GTU_STATUS)
      next_rdata = {30'h00000000, l2, l1};
    else
      next_err = 1'b1;
  end

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= setup;
      pslverr_out <= setup & next_err;
      prdata_out  <= setup ? next_rdata : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, latches and outputs

  always @(posedge core_clk_in) begin
    if (!nrst_in) begin
      pre    <= {PRE_W{1'b0}};
      cnt    <= 80'h0;
      ctl    <= 80'h0;
      capreg <= `GTU_RST_WORD;
      capctl <= `GTU_RST_WORD;
      l1     <= 1'b0;
      l1d    <= 1'b0;
      l2     <= 1'b0;
      l2d    <= 1'b0;
      core_one_toggle_pin_out <= 1'b0;
      core_two_toggle_pin_out <= 1'b0;
      capcom_clock_out        <= 1'b0;
    end else begin
      // one free-running prescaler keeps every timer on the same tick phase
      pre <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
      cnt <= next_cnt;
      // software writes win over counting in the same cycle
      if (wr_acc && !pslverr_out) begin
        if (paddr_in < (`GTU_CTL_BASE + 8'h14))
          ctl[(widx - `GTU_CTL_BASE/4)*16 +: 16] <= pwdata_in[15:0];
        else if (paddr_in >= `GTU_CNT_BASE && paddr_in < `GTU_CAPTURE_RELOAD_REG)
          cnt[(widx - `GTU_CNT_BASE/4)*16 +: 16] <= pwdata_in[15:0];
        else if (paddr_in == `GTU_CAPCTL)
          capctl <= pwdata_in[15:0];
      end
      // capture aux timer two; hardware wins over a software write
      if (cap_ev)
        capreg <= cnt[63:48];
      else if (wr_acc && !pslverr_out && paddr_in == `GTU_CAPTURE_RELOAD_REG)
        capreg <= pwdata_in[15:0];
      l1  <= l1 ^ wrap[1];
      l1d <= l1;
      l2  <= l2 ^ wrap[4];
      l2d <= l2;
      core_one_toggle_pin_out <= l1 ^ wrap[1];
      core_two_toggle_pin_out <= l2 ^ wrap[4];
      capcom_clock_out <= wrap[4];
    end
  end

endmodule

// *** pkg/gtu_timer_regs.vh ***
// register map, field positions and reset values of the general timer unit
// assumes a 32-bit apb slave with word-aligned byte addresses
`ifndef GTU_TIMER_REGS_VH
`define GTU_TIMER_REGS_VH

// control registers of the five timers, one word apart
`define GTU_CTL_BASE      8'h00
`define GTU_CNT_BASE      8'h20
`define GTU_CAPTURE_RELOAD_REG        8'h34
`define GTU_CAPCTL        8'h38
`define GTU_STATUS        8'h3C

// timer control fields
`define GTU_F_PRE_LO      0
`define GTU_F_MODE_LO     3
`define GTU_F_GATE_LVL    5
`define GTU_F_RUN         6
`define GTU_F_DOWN        7
`define GTU_F_EXT_DIR     8
`define GTU_F_FUNC_LO     9
`define GTU_F_TRIG_RISE   11
`define GTU_F_TRIG_FALL   12
`define GTU_F_TRIG_PIN    13
`define GTU_F_CHAIN       14

// capture/reload control fields
`define GTU_C_PIN_RISE    0
`define GTU_C_PIN_FALL    1
`define GTU_C_CORE_IN     2
`define GTU_C_CORE_DIR    3
`define GTU_C_CLEAR       4
`define GTU_C_RELOAD      5

// modes and auxiliary functions
`define GTU_MODE_TIMER    2'h0
`define GTU_MODE_GATED    2'h1
`define GTU_MODE_COUNTER  2'h2
`define GTU_MODE_INCR     2'h3
`define GTU_FUNC_CAPTURE  2'h1
`define GTU_FUNC_RELOAD   2'h2

// finest resolution as a power of two of system clocks
`define GTU_BASE_ONE      4'h2
`define GTU_BASE_TWO      4'h1

`define GTU_RST_WORD      16'h0000
`define GTU_MAX_CNT       16'hFFFF

`endif

// *** test/gtu_timer_props.sv ***
// checker: apb answer timing, toggle pin spacing, capture/compare clock pulses
// assumes it sees only the ports of gtu_timer_unit on one clock
`timescale 1ns/1ps
module gtu_timer_props (
  input wire        core_clk_in,
  input wire        nrst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  input wire        core_one_toggle_pin_out,
  input wire        core_two_toggle_pin_out,
  input wire        capcom_clock_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    psel_in && penable_in && pready_out;
  endsequence
  ////////////////////////////////////////////////////////////
  a_ready_next: assert property (s_setup |=> s_answer)
    else $error("no answer after setup");
  a_ready_cause: assert property (pready_out |-> $past(psel_in) && !$past(penable_in))
    else $error("answer without setup");
  a_err_misalign: assert property (s_setup and paddr_in[1:0] != 2'h0 |=> pslverr_out)
    else $error("misaligned access not refused");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error outside answer");
  a_rdata_quiet: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_one_spacing: assert property (
    $changed(core_one_toggle_pin_out) |=> $stable(core_one_toggle_pin_out)[*3])
    else $error("core one wraps too fast");
  a_two_spacing: assert property (
    $changed(core_two_toggle_pin_out) |=> $stable(core_two_toggle_pin_out))
    else $error("core two wraps too fast");
  a_capcom_pulse: assert property (capcom_clock_out |=> !capcom_clock_out)
    else $error("capcom clock longer than one cycle");
  a_capcom_wrap: assert property ($changed(core_two_toggle_pin_out) |->
    capcom_clock_out)
    else $error("core two wrap without capcom clock");
endmodule

bind gtu_timer_unit gtu_timer_props u_props (.core_clk_in, .nrst_in, .psel_in,
  .penable_in, .paddr_in, .prdata_out, .pready_out, .pslverr_out,
  .core_one_toggle_pin_out, .core_two_toggle_pin_out, .capcom_clock_out);

// *** test/gtu_quad_sensor.sv ***
// incremental position sensor: two phase lines, one step per request
// assumes requests far enough apart for the timer to sample each phase
`timescale 1ns/1ps
module gtu_quad_sensor (
  input  wire clk_in,
  input  wire nrst_in,
  input  wire step_in,
  input  wire down_in,
  output wire a_out,
  output wire b_out
);
  reg [1:0] pos;
  assign a_out = pos[1];
  assign b_out = pos[1] ^ pos[0];
  always @(posedge clk_in) begin
    if (!nrst_in)
      pos <= 2'h0;
    else if (step_in)
      pos <= down_in ? pos - 2'h1 : pos + 2'h1;
  end
endmodule

// *** test/gtu_timer_unit_tb.sv ***
// testbench of the general timer unit: apb tasks and one task per scenario
// assumes a synchronous low reset; every apb transfer waits for pready
`timescale 1ns/1ps
module gtu_timer_unit_tb;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [4:0]  tin = 5'h00;
  reg  [4:0]  din = 5'h00;
  reg         cap = 1'b0;
  reg         qreq = 1'b0;
  reg         qdn = 1'b0;
  reg         er;
  reg  [31:0] rd;
  wire [31:0] prdata;
  wire        pready, pslverr, t1p, t2p, ccl, qa, qb;
  integer     err_total = 0, checks = 0, cyc = 0, n, a, c1, c2;
  always #25 clk = ~clk;
  gtu_timer_unit DUT (.core_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .timer_input_pin_in({tin[4:2], qa, tin[0]}), .direction_input_pin_in({din[4:2], qb, din[0]}),
    .capture_trigger_pin_in(cap), .core_one_toggle_pin_out(t1p),
    .core_two_toggle_pin_out(t2p), .capcom_clock_out(ccl));
  gtu_quad_sensor u_sensor (.clk_in(clk), .nrst_in(nrst), .step_in(qreq), .down_in(qdn),
    .a_out(qa), .b_out(qb));
  ////////////////////////////////////////////////////////////
  task test_done;
    begin
      if (err_total == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input wr, input [7:0] ad, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
        @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // cycles until the core one toggle pin changes
  task span(output integer c);
    reg v;
    begin
      v = t1p;
      c = 0;
      while (t1p === v && c < 200) begin
        @(posedge clk);
        c = c + 1;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    integer i;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        apb(1'b0, 8'(32 + 4 * i), 32'h0);
        chk(er, 1'b0);
        chk(rd, 32'h0);
      end
      apb(1'b1, 8'h20, 32'hFFFFFFFF);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0000FFFF);
      apb(1'b0, 8'h14, 32'h0);
      chk(er, 1'b1);
      apb(1'b0, 8'h21, 32'h0);
      chk(er, 1'b1);
    end
  endtask
  task t_rate;
    begin
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b1, 8'h04, 32'h40);
      repeat (400) @(posedge clk);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd >= 97 && rd <= 104, 1'b1);
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b1, 8'h04, 32'hC0);
      repeat (20) @(posedge clk);
      apb(1'b0, 8'h24, 32'h0);
      chk(rd >= 32'hFFF9 && rd <= 32'hFFFD, 1'b1);
      apb(1'b1, 8'h04, 32'h0);
      chk(t1p, 1'b1);
    end
  endtask
  task t_count;
    begin
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h50);
      repeat (10) begin
        repeat (4) @(posedge clk);
        tin[0] <= ~tin[0];
      end
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h5);
      din[0] <= 1'b1;
      apb(1'b1, 8'h00, 32'h150);
      repeat (6) begin
        repeat (4) @(posedge clk);
        tin[0] <= ~tin[0];
      end
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, 8'h00, 32'h0);
    end
  endtask
  task t_gate;
    begin
      apb(1'b1, 8'h28, 32'h0);
      apb(1'b1, 8'h08, 32'h68);
      repeat (200) @(posedge clk);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd, 32'h0);
      tin[2] <= 1'b1;
      repeat (200) @(posedge clk);
      tin[2] <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h28, 32'h0);
      chk(rd >= 48 && rd <= 52, 1'b1);
      apb(1'b1, 8'h08, 32'h0);
    end
  endtask
  task t_quad;
    integer i;
    begin
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b1, 8'h04, 32'h58);
      for (i = 0; i < 11; i = i + 1) begin
        @(posedge clk);
        qreq <= 1'b1;
        qdn <= (i >= 8);
        @(posedge clk);
        qreq <= 1'b0;
        repeat (6) @(posedge clk);
      end
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, 8'h04, 32'h0);
    end
  endtask
  task t_pwm;
    begin
      apb(1'b1, 8'h20, 32'hFFFE);
      apb(1'b1, 8'h28, 32'hFFFC);
      apb(1'b1, 8'h00, 32'hC00);
      apb(1'b1, 8'h08, 32'h1400);
      apb(1'b1, 8'h24, 32'hFFFF);
      apb(1'b1, 8'h04, 32'h40);
      span(n);
      span(n);
      a = t1p;
      span(c1);
      span(c2);
      chk(a ? c1 : c2, 32'd8);
      chk(a ? c2 : c1, 32'd16);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'hFFFE);
      apb(1'b1, 8'h04, 32'h0);
    end
  endtask
  task t_chain;
    begin
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h4040);
      apb(1'b1, 8'h24, 32'hFFFE);
      apb(1'b1, 8'h04, 32'h40);
      repeat (20) @(posedge clk);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 8'h24, 32'h1234);
      apb(1'b1, 8'h00, 32'hA00);
      tin[0] <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h1234);
      tin[0] <= 1'b0;
      apb(1'b1, 8'h00, 32'h0);
    end
  endtask
  task t_two;
    begin
      apb(1'b1, 8'h30, 32'hFFF0);
      apb(1'b1, 8'h10, 32'h40);
      n = 0;
      repeat (40) begin
        @(posedge clk);
        n = n + ccl;
      end
      apb(1'b1, 8'h10, 32'h0);
      chk(n, 32'h1);
      chk(t2p, 1'b1);
      apb(1'b1, 8'h2C, 32'h0);
      apb(1'b1, 8'h38, 32'h11);
      apb(1'b1, 8'h0C, 32'h40);
      repeat (100) @(posedge clk);
      cap <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h34, 32'h0);
      chk(rd >= 45 && rd <= 60, 1'b1);
      apb(1'b0, 8'h2C, 32'h0);
      chk(rd < 16, 1'b1);
      cap <= 1'b0;
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h2C, 32'h55);
      apb(1'b1, 8'h38, 32'h0C);
      @(posedge clk);
      qreq <= 1'b1;
      @(posedge clk);
      qreq <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h34, 32'h0);
      chk(rd, 32'h55);
      apb(1'b1, 8'h0C, 32'h50);
      repeat (4) begin
        repeat (4) @(posedge clk);
        tin[3] <= 1'b1;
        repeat (4) @(posedge clk);
        tin[3] <= 1'b0;
      end
      repeat (6) @(posedge clk);
      apb(1'b0, 8'h2C, 32'h0);
      chk(rd, 32'h59);
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h38, 32'h20);
      apb(1'b1, 8'h30, 32'hFFFF);
      apb(1'b1, 8'h10, 32'h40);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b0, 8'h30, 32'h0);
      chk(rd >= 32'h55 && rd <= 32'h57, 1'b1);
    end
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      test_done;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_regs;
    t_rate;
    t_count;
    t_gate;
    t_quad;
    t_pwm;
    t_chain;
    t_two;
    test_done;
  end
endmodule
